// [smram_pkg.sv]
`default_nettype none
package smram_pkg;

  // ----------------------------------------------------------------
  // configuration space offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SMRAM_CTRL_OFFSET = 8'h9D;
  localparam logic [7:0] EXT_CTRL_OFFSET = 8'h9E;
  localparam logic [7:0] SMRAM_CTRL_RESET = 8'h02;
  localparam logic [7:0] EXT_CTRL_RESET = 8'h38;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned EXT_HIGH_EN_BIT = 7;
  localparam int unsigned EXT_FLAG_BIT = 6;
  localparam int unsigned EXT_CACHE_BIT = 5;
  localparam int unsigned EXT_L1_BIT = 4;
  localparam int unsigned EXT_L2_BIT = 3;
  localparam int unsigned EXT_SIZE_LSB = 1;
  localparam int unsigned EXT_SEG_EN_BIT = 0;
  localparam int unsigned CTRL_OPEN_BIT = 6;
  localparam int unsigned CTRL_LOCK_BIT = 4;
  localparam int unsigned CTRL_GLOBAL_BIT = 3;
  localparam logic [2:0] CTRL_BASE_SEG = 3'h2;
  localparam logic [2:0] CACHE_BITS_RO = 3'h7;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam logic [31:0] HIGH_FIRST = 32'hFEDA0000;
  localparam logic [31:0] HIGH_LAST = 32'hFEDBFFFF;
  localparam logic [31:0] LEGACY_FIRST = 32'h000A0000;
  localparam logic [31:0] HIGH_TO_LEGACY = HIGH_FIRST - LEGACY_FIRST;
  localparam logic [31:0] EXT_DRAM_LIMIT = 32'h10000000;
  localparam logic [31:0] SEG_BYTES_512K = 32'h00080000;
  localparam logic [31:0] SEG_BYTES_1M = 32'h00100000;
  localparam logic [1:0] TSEG_SIZE_512K = 2'h2;
  localparam logic [1:0] TSEG_SIZE_1M = 2'h3;

  // ----------------------------------------------------------------
  // access routing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ROUTE_NONE = 2'b00,
    ROUTE_DRAM = 2'b01,
    ROUTE_HUB = 2'b10
  } route_t;

endpackage
`default_nettype wire

// [smram_decode.sv]
`default_nettype none
module smram_decode (
  input wire logic [31:0] addr,
  input wire logic smm,
  input wire logic global_en,
  input wire logic open_en,
  input wire logic lock,
  input wire logic high_en,
  input wire logic seg_en,
  input wire logic [1:0] tseg_size,
  input wire logic [31:0] top_of_memory,
  output smram_pkg::route_t route,
  output logic [31:0] dram_addr,
  output logic invalid,
  output logic high_hit,
  output logic tseg_hit
);

  logic ext_in_use;
  logic [31:0] mem_limit;
  logic [31:0] seg_bytes;
  logic seg_valid;
  logic smm_ok;

  // window hits and the capped top of memory
  always_comb begin
    ext_in_use = global_en && (high_en || seg_en);
    mem_limit = top_of_memory;
    if (ext_in_use && top_of_memory > smram_pkg::EXT_DRAM_LIMIT) begin
      mem_limit = smram_pkg::EXT_DRAM_LIMIT;
    end
    seg_valid = tseg_size == smram_pkg::TSEG_SIZE_512K || tseg_size == smram_pkg::TSEG_SIZE_1M;
    seg_bytes = (tseg_size == smram_pkg::TSEG_SIZE_1M) ? smram_pkg::SEG_BYTES_1M
                                                      : smram_pkg::SEG_BYTES_512K;
    high_hit = global_en && high_en && addr >= smram_pkg::HIGH_FIRST
               && addr <= smram_pkg::HIGH_LAST;
    tseg_hit = global_en && seg_en && seg_valid && mem_limit >= seg_bytes
               && addr >= mem_limit - seg_bytes && addr < mem_limit;
    smm_ok = smm || (open_en && !lock);
  end

  // routing: protected windows go to dram only for smm-capable cycles
  always_comb begin
    route = smram_pkg::ROUTE_HUB;
    dram_addr = addr;
    invalid = 1'b0;
    if (high_hit) begin
      if (smm_ok) begin
        route = smram_pkg::ROUTE_DRAM;
        dram_addr = addr - smram_pkg::HIGH_TO_LEGACY;
      end else begin
        invalid = 1'b1;
      end
    end else if (tseg_hit) begin
      if (smm_ok) begin
        route = smram_pkg::ROUTE_DRAM;
      end else begin
        invalid = 1'b1;
      end
    end else if (addr < mem_limit) begin
      route = smram_pkg::ROUTE_DRAM;
    end
  end

endmodule // smram_decode
`default_nettype wire

// [extended_smram_control.sv]
`default_nettype none
// Summary of operation
// - high window FEDA0000-FEDBFFFF remaps to A0000-BFFFF when both enables set
// - bit 7 enables high SMM space above 1 MB; 0 disables it
// - high enable ignores writes once the lock bit is set
// - non-SMM access to high or top segment without open sets bit 6
// - bits 5, 4 and 3 are read-only and always read one
// - size field 10 selects 512 KB, 11 selects 1 MB; 00, 01 reserved
// - enabled top segment is not claimed for non-SMM access without open; those go to hub
// - top segment decodes only when global enable and bit 0 are set
// - size field and segment enable ignore writes once locked
// - with extended SMRAM in use, addressable SDRAM is capped at 256 MB
// - extended control register is 8 bits at 9Eh, reset value 38h
// - global enable, bit 3 of 9Dh, gates every extended function
// - open bit, bit 6 of 9Dh, exposes SMM space while unlocked
// - lock bit, bit 4 of 9Dh, set by write, cleared only by reset
module extended_smram_control (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  output logic [7:0] cfg_rdata,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_smm,
  input wire logic [31:0] top_of_memory,
  output logic acc_done,
  output logic acc_to_dram,
  output logic acc_to_hub,
  output logic [31:0] acc_dram_addr
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic global_smram_enable_q, global_smram_enable_d;
  logic smm_space_open_q, smm_space_open_d;
  logic smm_space_lock_q, smm_space_lock_d;
  logic high_smram_enable_q, high_smram_enable_d;
  logic invalid_smram_access_flag_q, invalid_smram_access_flag_d;
  logic [1:0] top_segment_size_q, top_segment_size_d;
  logic top_segment_enable_q, top_segment_enable_d;
  logic [7:0] cfg_rdata_d;
  logic [7:0] ctrl_view;
  logic [7:0] ext_view;
  logic wr_ctrl, wr_ext, rd_hit_ctrl, rd_hit_ext;

  // ----------------------------------------------------------------
  // access path state
  // ----------------------------------------------------------------
  logic acc_done_d, acc_to_dram_d, acc_to_hub_d;
  logic [31:0] acc_dram_addr_d;
  smram_pkg::route_t dec_route;
  logic [31:0] dec_addr;
  logic dec_invalid, dec_high_hit, dec_tseg_hit;

  // window decoder on the live register values
  smram_decode u_decode (
    .addr(acc_addr),
    .smm(acc_smm),
    .global_en(global_smram_enable_q),
    .open_en(smm_space_open_q),
    .lock(smm_space_lock_q),
    .high_en(high_smram_enable_q),
    .seg_en(top_segment_enable_q),
    .tseg_size(top_segment_size_q),
    .top_of_memory(top_of_memory),
    .route(dec_route),
    .dram_addr(dec_addr),
    .invalid(dec_invalid),
    .high_hit(dec_high_hit),
    .tseg_hit(dec_tseg_hit)
  );

  // read views of both registers
  always_comb begin
    ctrl_view = {1'b0, smm_space_open_q, 1'b0, smm_space_lock_q,
                 global_smram_enable_q, smram_pkg::CTRL_BASE_SEG};
    ext_view = {high_smram_enable_q, invalid_smram_access_flag_q,
                smram_pkg::CACHE_BITS_RO, top_segment_size_q,
                top_segment_enable_q};
    wr_ctrl = cfg_wr && cfg_addr == smram_pkg::SMRAM_CTRL_OFFSET;
    wr_ext = cfg_wr && cfg_addr == smram_pkg::EXT_CTRL_OFFSET;
    rd_hit_ctrl = cfg_rd && cfg_addr == smram_pkg::SMRAM_CTRL_OFFSET;
    rd_hit_ext = cfg_rd && cfg_addr == smram_pkg::EXT_CTRL_OFFSET;
  end

  // next register values, writes and the hardware-set flag
  always_comb begin
    global_smram_enable_d = global_smram_enable_q;
    smm_space_open_d = smm_space_open_q;
    smm_space_lock_d = smm_space_lock_q;
    high_smram_enable_d = high_smram_enable_q;
    invalid_smram_access_flag_d = invalid_smram_access_flag_q;
    top_segment_size_d = top_segment_size_q;
    top_segment_enable_d = top_segment_enable_q;
    cfg_rdata_d = cfg_rdata;
    if (clk_en) begin
      if (wr_ctrl && !smm_space_lock_q) begin
        global_smram_enable_d = cfg_wdata[smram_pkg::CTRL_GLOBAL_BIT];
        smm_space_open_d = cfg_wdata[smram_pkg::CTRL_OPEN_BIT];
        smm_space_lock_d = cfg_wdata[smram_pkg::CTRL_LOCK_BIT];
        if (cfg_wdata[smram_pkg::CTRL_LOCK_BIT]) begin
          smm_space_open_d = 1'b0; // locking closes the open window
        end
      end
      if (wr_ext) begin
        if (!smm_space_lock_q) begin
          high_smram_enable_d = cfg_wdata[smram_pkg::EXT_HIGH_EN_BIT];
          top_segment_size_d = cfg_wdata[smram_pkg::EXT_SIZE_LSB +: 2];
          top_segment_enable_d = cfg_wdata[smram_pkg::EXT_SEG_EN_BIT];
        end
        if (cfg_wdata[smram_pkg::EXT_FLAG_BIT]) begin
          invalid_smram_access_flag_d = 1'b0;
        end
      end
      if (acc_valid && dec_invalid) begin
        invalid_smram_access_flag_d = 1'b1; // set beats clear
      end
      if (rd_hit_ctrl) begin
        cfg_rdata_d = ctrl_view;
      end else if (rd_hit_ext) begin
        cfg_rdata_d = ext_view;
      end else if (cfg_rd) begin
        cfg_rdata_d = smram_pkg::READ_UNMAPPED;
      end
    end
  end

  // register the configuration state
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      global_smram_enable_q <= smram_pkg::SMRAM_CTRL_RESET[smram_pkg::CTRL_GLOBAL_BIT];
      smm_space_open_q <= smram_pkg::SMRAM_CTRL_RESET[smram_pkg::CTRL_OPEN_BIT];
      smm_space_lock_q <= smram_pkg::SMRAM_CTRL_RESET[smram_pkg::CTRL_LOCK_BIT];
      high_smram_enable_q <= smram_pkg::EXT_CTRL_RESET[smram_pkg::EXT_HIGH_EN_BIT];
      invalid_smram_access_flag_q <= smram_pkg::EXT_CTRL_RESET[smram_pkg::EXT_FLAG_BIT];
      top_segment_size_q <= smram_pkg::EXT_CTRL_RESET[smram_pkg::EXT_SIZE_LSB +: 2];
      top_segment_enable_q <= smram_pkg::EXT_CTRL_RESET[smram_pkg::EXT_SEG_EN_BIT];
      cfg_rdata <= smram_pkg::READ_UNMAPPED;
    end else begin
      global_smram_enable_q <= global_smram_enable_d;
      smm_space_open_q <= smm_space_open_d;
      smm_space_lock_q <= smm_space_lock_d;
      high_smram_enable_q <= high_smram_enable_d;
      invalid_smram_access_flag_q <= invalid_smram_access_flag_d;
      top_segment_size_q <= top_segment_size_d;
      top_segment_enable_q <= top_segment_enable_d;
      cfg_rdata <= cfg_rdata_d;
    end
  end

  // next access answer, one cycle after the request
  always_comb begin
    acc_done_d = acc_done;
    acc_to_dram_d = acc_to_dram;
    acc_to_hub_d = acc_to_hub;
    acc_dram_addr_d = acc_dram_addr;
    if (clk_en) begin
      acc_done_d = acc_valid;
      acc_to_dram_d = acc_valid && dec_route == smram_pkg::ROUTE_DRAM;
      acc_to_hub_d = acc_valid && dec_route == smram_pkg::ROUTE_HUB;
      if (acc_valid) begin
        acc_dram_addr_d = dec_addr;
      end
    end
  end

  // register the access answer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      acc_done <= 1'b0;
      acc_to_dram <= 1'b0;
      acc_to_hub <= 1'b0;
      acc_dram_addr <= 32'h00000000;
    end else begin
      acc_done <= acc_done_d;
      acc_to_dram <= acc_to_dram_d;
      acc_to_hub <= acc_to_hub_d;
      acc_dram_addr <= acc_dram_addr_d;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  AST_HIGH_REMAP: assert property (
    clk_en && acc_valid && acc_smm && global_smram_enable_q && high_smram_enable_q
    && acc_addr >= smram_pkg::HIGH_FIRST && acc_addr <= smram_pkg::HIGH_LAST
    |=> acc_to_dram && !acc_to_hub
        && acc_dram_addr == $past(acc_addr) - smram_pkg::HIGH_TO_LEGACY)
    else $error("high window access not remapped to legacy area");
  AST_HIGH_OFF: assert property (
    clk_en && acc_valid && !high_smram_enable_q && acc_addr >= smram_pkg::HIGH_FIRST
    && acc_addr <= smram_pkg::HIGH_LAST |=> acc_to_hub)
    else $error("high window decoded while disabled");
  AST_LOCK_HIGH: assert property (
    clk_en && smm_space_lock_q && wr_ext |=> high_smram_enable_q == $past(high_smram_enable_q))
    else $error("high enable changed while locked");
  AST_FLAG_SET: assert property (
    clk_en && acc_valid && !acc_smm && !smm_space_open_q && (dec_high_hit || dec_tseg_hit)
    |=> invalid_smram_access_flag_q)
    else $error("invalid access flag not set");
  AST_FLAG_CLEAR: assert property (
    clk_en && wr_ext && cfg_wdata[6] && !(acc_valid && dec_invalid)
    |=> !invalid_smram_access_flag_q)
    else $error("write one did not clear the flag");
  AST_RO_ONES: assert property (
    clk_en && rd_hit_ext |=> cfg_rdata[5:3] == 3'h7)
    else $error("cache bits did not read as one");
  AST_TSEG_HUB: assert property (
    clk_en && acc_valid && !acc_smm && !smm_space_open_q && dec_tseg_hit
    |=> acc_to_hub && !acc_to_dram)
    else $error("top segment claimed for outside access");
  AST_LOCK_TSEG: assert property (
    clk_en && smm_space_lock_q && wr_ext
    |=> $stable(top_segment_size_q) && $stable(top_segment_enable_q))
    else $error("top segment settings changed while locked");
  AST_LIMIT: assert property (
    clk_en && acc_valid && global_smram_enable_q && top_segment_enable_q
    && acc_addr >= smram_pkg::EXT_DRAM_LIMIT && !dec_high_hit |=> acc_to_hub)
    else $error("access above 256 MB claimed with extended space on");
  AST_LOCK_STICKY: assert property (
    smm_space_lock_q |=> smm_space_lock_q [*2])
    else $error("lock bit cleared without reset");
  AST_FLAG_KEEP: assert property (
    clk_en && wr_ext && !cfg_wdata[6] && invalid_smram_access_flag_q
    |=> invalid_smram_access_flag_q)
    else $error("write zero disturbed the flag");

  COV_REMAP: cover property (clk_en && acc_valid && acc_smm && dec_high_hit ##1 acc_to_dram);
  COV_FLAG: cover property (clk_en && acc_valid && dec_invalid ##1 invalid_smram_access_flag_q);
  COV_LOCKED_WRITE: cover property (smm_space_lock_q && clk_en && wr_ext);

endmodule // extended_smram_control
`default_nettype wire

// [host_bus_model.sv]
`default_nettype none
// ----------------------------------------------------------------
// processor host bus: one memory access at a time
// ----------------------------------------------------------------
module host_bus_model (
  input wire logic clk_sys,
  output logic acc_valid,
  output logic [31:0] acc_addr,
  output logic acc_smm
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle bus at time zero
  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h00000000;
    acc_smm = 1'b0;
  end

  // one-cycle request; idle lines scrambled so no stale value helps
  task automatic issue(input logic [31:0] a, input logic s);
    @(posedge clk_sys);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_smm <= s;
    @(posedge clk_sys);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
    acc_smm <= ~s;
  endtask
endmodule // host_bus_model
`default_nettype wire

// [extended_smram_control_tb.sv]
`default_nettype none
module extended_smram_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] DRAM = 2'h2;
  localparam logic [1:0] HUB = 2'h1;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  logic cfg_rd = 1'b0;
  logic cfg_wr = 1'b0;
  logic [7:0] cfg_addr = 8'h00;
  logic [7:0] cfg_wdata = 8'h00;
  logic [31:0] top_of_memory = 32'h08000000;
  logic [7:0] cfg_rdata;
  logic acc_valid, acc_smm, acc_done, acc_to_dram, acc_to_hub;
  logic [31:0] acc_addr, acc_dram_addr;
  int error_cnt = 0;
  int n_tests = 0;
  int cyc = 0;

  // 20 MHz clock
  always #25 clk_sys = ~clk_sys;

  extended_smram_control i_dut (.clk_sys(clk_sys), .reset(reset), .clk_en(clk_en),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_smm(acc_smm), .top_of_memory(top_of_memory), .acc_done(acc_done),
    .acc_to_dram(acc_to_dram), .acc_to_hub(acc_to_hub), .acc_dram_addr(acc_dram_addr));
  host_bus_model i_host (.clk_sys(clk_sys), .acc_valid(acc_valid), .acc_addr(acc_addr),
    .acc_smm(acc_smm));

  // ----------------------------------------------------------------
  // compare, bus and verdict tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask

  // read data is registered on the edge that takes cfg_rd, checked 1 ns later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    cfg_rd <= 1'b1;
    cfg_addr <= a;
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1;
    chk8(cfg_rdata, e);
  endtask

  // access through the host model, route and remapped address judged
  task automatic acc(input logic [31:0] a, input logic s, input logic [1:0] rt,
                     input logic [31:0] da);
    i_host.issue(a, s);
    #1;
    chk8({5'h00, acc_done, acc_to_dram, acc_to_hub}, {6'h01, rt});
    if (rt == DRAM)
      chk32(acc_dram_addr, da);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(8'h9E, 8'h38);
    rd(8'h9D, 8'h02);
    rd(8'hA0, 8'h00);
    wr(8'h9E, 8'h00);
    rd(8'h9E, 8'h38);
    wr(8'h9E, 8'hFF);
    rd(8'h9E, 8'hBF);
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(8'h9E, 8'h00);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(8'h9E, 8'hBF);
    wr(8'h9E, 8'h00);
  endtask

  task automatic t_high;
    wr(8'h9D, 8'h08);
    wr(8'h9E, 8'h80);
    acc(32'hFEDA1234, 1'b1, DRAM, 32'h000A1234);
    acc(32'hFEDBFFFF, 1'b1, DRAM, 32'h000BFFFF);
    acc(32'hFEDC0000, 1'b1, HUB, 32'h0);
    acc(32'hFED9FFFF, 1'b1, HUB, 32'h0);
    wr(8'h9E, 8'h00);
    acc(32'hFEDA0000, 1'b1, HUB, 32'h0);
    wr(8'h9E, 8'h80);
    wr(8'h9D, 8'h00);
    acc(32'hFEDA0000, 1'b1, HUB, 32'h0);
  endtask

  task automatic t_flag;
    wr(8'h9D, 8'h08);
    acc(32'hFEDA0010, 1'b0, HUB, 32'h0);
    rd(8'h9E, 8'hF8);
    wr(8'h9E, 8'h80);
    rd(8'h9E, 8'hF8);
    wr(8'h9E, 8'hC0);
    rd(8'h9E, 8'hB8);
    wr(8'h9D, 8'h48);
    acc(32'hFEDA0010, 1'b0, DRAM, 32'h000A0010);
    rd(8'h9E, 8'hB8);
  endtask

  task automatic t_tseg;
    wr(8'h9D, 8'h08);
    wr(8'h9E, 8'h05);
    acc(32'h07F80000, 1'b1, DRAM, 32'h07F80000);
    acc(32'h07F80000, 1'b0, HUB, 32'h0);
    rd(8'h9E, 8'h7D);
    wr(8'h9E, 8'h45);
    acc(32'h07F7FFFF, 1'b0, DRAM, 32'h07F7FFFF);
    wr(8'h9E, 8'h07);
    acc(32'h07F00000, 1'b0, HUB, 32'h0);
    acc(32'h07EFFFFF, 1'b0, DRAM, 32'h07EFFFFF);
    wr(8'h9E, 8'h43);
    acc(32'h07F80000, 1'b0, DRAM, 32'h07F80000);
    wr(8'h9E, 8'h05);
    wr(8'h9D, 8'h00);
    acc(32'h07F80000, 1'b0, DRAM, 32'h07F80000);
    rd(8'h9E, 8'h3D);
  endtask

  task automatic t_cap;
    @(posedge clk_sys);
    top_of_memory <= 32'h20000000;
    wr(8'h9D, 8'h08);
    wr(8'h9E, 8'h01);
    acc(32'h10000000, 1'b1, HUB, 32'h0);
    acc(32'h0FFFFFFF, 1'b1, DRAM, 32'h0FFFFFFF);
    wr(8'h9E, 8'h00);
    acc(32'h10000000, 1'b1, DRAM, 32'h10000000);
    @(posedge clk_sys);
    top_of_memory <= 32'h08000000;
  endtask

  task automatic t_lock;
    wr(8'h9E, 8'h87);
    wr(8'h9D, 8'h58);
    rd(8'h9D, 8'h1A);
    wr(8'h9E, 8'h00);
    rd(8'h9E, 8'hBF);
    wr(8'h9D, 8'h00);
    rd(8'h9D, 8'h1A);
    acc(32'hFEDA0020, 1'b1, DRAM, 32'h000A0020);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h9D, 8'h02);
    rd(8'h9E, 8'h38);
  endtask

  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_high();
    t_flag();
    t_tseg();
    t_cap();
    t_lock();
    print_verdict();
  end
endmodule // extended_smram_control_tb
`default_nettype wire
